/* logic/sbcmd_defs.svh */
/*
 * shared constants of the sideband command block: frame fields, command and
 * response codes, register offsets and reset values.
 * assumes it is included by bare name from files that need the numbers.
 */
`ifndef SBCMD_DEFS_SVH
`define SBCMD_DEFS_SVH

// frame fields
`define SB_BCAST_BYTE 8'hff
`define SB_ETHERTYPE 16'h88f8
`define SB_PKG_CHAN 5'h1f
`define SB_MIN_FRAME 7'd64
`define SB_HDR_START 7'd14
`define SB_FCS_START 7'd60

// command and response codes
`define CMD_CLEAR_INIT 8'h00
`define CMD_SELECT 8'h01
`define CMD_DESELECT 8'h02
`define RSP_FLAG 8'h80

// response and reason codes
`define RESP_OK 16'h0000
`define RESP_FAIL 16'h0001
`define REASON_NONE 16'h0000
`define REASON_INIT_REQ 16'h0001

// arbitration-disable byte
`define ARB_DIS_BIT 0

// register offsets, byte addresses
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_LASTCMD 8'h08

// control field positions and reset values
`define CTRL_PKG_ID_LSB 0
`define CTRL_ARB_CAP_BIT 3
`define CTRL_FORCE_INIT_BIT 4
`define CTRL_RESET 32'h0000_0008

// deselect to high impedance interval
`define T1_NS 200
`define T1_CYCLES (`T1_NS / 100)

`endif

/* logic/sbcmd_pkg.sv */
/*
 * types of the sideband command block.
 * assumes sbcmd_defs.svh is compiled alongside for the numbers.
 */
package sbcmd_pkg;
	typedef enum logic [2:0] {
		st_idle,
		st_rx,
		st_exec,
		st_tx,
		st_desel_wait
	} ctl_state_t;

	typedef logic [7:0] byte_t;
endpackage

/* logic/sbcmd_rx.sv */
/*
 * command frame parser: checks destination and ethertype, captures header
 * fields and bit 0 of the arbitration-disable byte.
 * assumes bytes framed by rx_valid and rx_last, with idle cycles allowed between bytes.
 */
`timescale 1ns/10ps
`include "sbcmd_defs.svh"

module sbcmd_rx (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// byte stream
	input wire sbcmd_pkg::byte_t rx_data,
	input wire logic rx_valid,
	input wire logic rx_last,
	// parsed command
	output logic cmd_valid,
	output sbcmd_pkg::byte_t cmd_mgr,
	output sbcmd_pkg::byte_t cmd_rev,
	output sbcmd_pkg::byte_t cmd_iid,
	output sbcmd_pkg::byte_t cmd_type,
	output sbcmd_pkg::byte_t cmd_chan,
	output logic cmd_arb_dis
);
	import sbcmd_pkg::*;

	logic [6:0] idx;
	logic good;
	// **********
	// field check
	// **********
	wire dst_ok = (idx > 7'd5) || (rx_data == `SB_BCAST_BYTE);
	wire et_ok = (idx == 7'd12) ? (rx_data == 8'(`SB_ETHERTYPE >> 8)) :
		(idx == 7'd13) ? (rx_data == 8'hf8) : 1'b1;

	// byte counter and capture; reserved bytes are never looked at
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			idx <= 7'd0;
			good <= 1'b1;
			cmd_valid <= 1'b0;
			cmd_mgr <= 8'h00;
			cmd_rev <= 8'h00;
			cmd_iid <= 8'h00;
			cmd_type <= 8'h00;
			cmd_chan <= 8'h00;
			cmd_arb_dis <= 1'b0;
		end else begin
			cmd_valid <= 1'b0;
			if (rx_valid) begin
				idx <= rx_last ? 7'd0 : idx + 7'd1;
				good <= rx_last ? 1'b1 : good & dst_ok & et_ok;
				if (rx_last)
					cmd_valid <= good && idx >= 7'd21;
				case (idx)
					7'd14: cmd_mgr <= rx_data;
					7'd15: cmd_rev <= rx_data;
					7'd17: cmd_iid <= rx_data;
					7'd18: cmd_type <= rx_data;
					7'd19: cmd_chan <= rx_data;
					7'd33: cmd_arb_dis <= rx_data[`ARB_DIS_BIT];
					default: ;
				endcase
			end
		end
	end
endmodule // sbcmd_rx

/* logic/sbcmd_tx.sv */
/*
 * response frame builder: broadcast destination, ethertype, header with
 * response type, response and reason codes, zero checksum, pad, fcs slot.
 * assumes the sink takes one byte per clock while tx_valid is high.
 */
`timescale 1ns/10ps
`include "sbcmd_defs.svh"

module sbcmd_tx (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// request
	input wire logic start,
	input wire sbcmd_pkg::byte_t rsp_mgr,
	input wire sbcmd_pkg::byte_t rsp_rev,
	input wire sbcmd_pkg::byte_t rsp_iid,
	input wire sbcmd_pkg::byte_t rsp_type,
	input wire sbcmd_pkg::byte_t rsp_chan,
	input wire logic [15:0] rsp_code,
	input wire logic [15:0] rsp_reason,
	// byte stream
	output sbcmd_pkg::byte_t tx_data,
	output logic tx_valid,
	output logic tx_last,
	output logic busy
);
	import sbcmd_pkg::*;

	logic [6:0] idx;
	logic [7:0] next_byte;

	// byte mux for the response layout
	always_comb begin
		case (idx)
			7'd0, 7'd1, 7'd2, 7'd3, 7'd4, 7'd5: next_byte = `SB_BCAST_BYTE;
			7'd12: next_byte = 8'h88;
			7'd13: next_byte = 8'hf8;
			7'd14: next_byte = rsp_mgr;
			7'd15: next_byte = rsp_rev;
			7'd17: next_byte = rsp_iid;
			7'd18: next_byte = rsp_type;
			7'd19: next_byte = rsp_chan;
			7'd21: next_byte = 8'h04; // payload length
			7'd30: next_byte = rsp_code[15:8];
			7'd31: next_byte = rsp_code[7:0];
			7'd32: next_byte = rsp_reason[15:8];
			7'd33: next_byte = rsp_reason[7:0];
			default: next_byte = 8'h00; // reserved, checksum zero, pad, fcs slot
		endcase
	end

	// frame sequencer; pad to minimum size
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			idx <= 7'd0;
			busy <= 1'b0;
			tx_valid <= 1'b0;
			tx_last <= 1'b0;
			tx_data <= 8'h00;
		end else begin
			tx_valid <= busy;
			tx_data <= next_byte;
			tx_last <= busy && idx == `SB_MIN_FRAME - 7'd1;
			if (start && !busy) begin
				busy <= 1'b1;
				idx <= 7'd0;
			end else if (busy) begin
				idx <= idx + 7'd1;
				if (idx == `SB_MIN_FRAME - 7'd1)
					busy <= 1'b0;
			end
		end
	end
endmodule // sbcmd_tx

/* logic/sbcmd_top.sv */
/*
 * sideband command interpreter: initial state handling, package selection,
 * hardware arbitration setting, and an axi4-lite register slave.
 * assumes byte streams synchronous to aclk and a single axi master.
 */
// Operation
// - accept broadcast frames with sideband ethertype and parse header fields
// - send responses with same header, response type, codes, checksum, pad, fcs
// - every supported command gets its matching response format
// - in initial state answer every command except clear-initial-state with initialization-required reason
// - clear-initial-state stops the initialization-required reason
// - after clear-initial-state every instance number counts as new
// - clear and select answered with types 0x80 and 0x81
// - select-package leaves deselected state and applies arbitration setting
// - any other command to package or its channels selects it
// - select addressed to package id with internal channel 0x1f
// - with arbitration on, arbitration grant guards output buffers
// - selection holds until deselect or all channels enter initial state
// - idle tri-state between packets leaves selection unchanged
// - one select enables all channels of a single-buffer package
// - arbitration-disable bit 0 sets bypass when one
// - without arbitration support ignore the bit, no error
// - deselect responds first, then deselects and floats outputs
`timescale 1ns/10ps
`include "sbcmd_defs.svh"

module sbcmd_top (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// command byte stream
	input wire sbcmd_pkg::byte_t rx_data,
	input wire logic rx_valid,
	input wire logic rx_last,
	// response byte stream toward the shared bus
	output sbcmd_pkg::byte_t tx_data,
	output logic tx_valid,
	output logic tx_last,
	output logic tx_oe,
	// hardware arbitration
	input wire logic arb_grant,
	output logic arb_bypass,
	// package state
	output logic pkg_selected,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import sbcmd_pkg::*;

	localparam logic [2:0] T1_COUNT = 3'(`T1_CYCLES);

	// ***************
	// declarations
	// ***************
	ctl_state_t state;
	logic cmd_valid;
	byte_t cmd_mgr, cmd_rev, cmd_iid, cmd_type, cmd_chan;
	logic cmd_arb_dis;
	logic init_state;
	logic [7:0] last_iid;
	logic last_iid_ok;
	logic [31:0] ctrl;
	logic [7:0] last_cmd;
	logic [15:0] rsp_code, rsp_reason;
	logic tx_start, tx_busy;
	logic [2:0] t1_cnt;
	logic [7:0] awaddr_q;
	logic aw_held, w_held;
	logic [31:0] wdata_q;
	logic force_init_q;

	// ***************
	// command decode
	// ***************
	function automatic logic addressed_to_pkg(input logic [7:0] chan, input logic [2:0] pkg);
		addressed_to_pkg = chan[7:5] == pkg;
	endfunction

	wire [2:0] pkg_id = ctrl[`CTRL_PKG_ID_LSB +: 3];
	wire arb_capable = ctrl[`CTRL_ARB_CAP_BIT];
	wire force_init = ctrl[`CTRL_FORCE_INIT_BIT];
	wire for_us = addressed_to_pkg(cmd_chan, pkg_id);
	wire is_pkg_cmd = cmd_chan[4:0] == `SB_PKG_CHAN;
	wire is_clear = cmd_type == `CMD_CLEAR_INIT;
	wire is_select = cmd_type == `CMD_SELECT && is_pkg_cmd;
	wire is_deselect = cmd_type == `CMD_DESELECT && is_pkg_cmd;
	wire init_rise = force_init && !force_init_q;

	sbcmd_rx u_rx (
		.aclk(aclk),
		.aresetn(aresetn),
		.rx_data(rx_data),
		.rx_valid(rx_valid),
		.rx_last(rx_last),
		.cmd_valid(cmd_valid),
		.cmd_mgr(cmd_mgr),
		.cmd_rev(cmd_rev),
		.cmd_iid(cmd_iid),
		.cmd_type(cmd_type),
		.cmd_chan(cmd_chan),
		.cmd_arb_dis(cmd_arb_dis)
	);

	sbcmd_tx u_tx (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(tx_start),
		.rsp_mgr(cmd_mgr),
		.rsp_rev(cmd_rev),
		.rsp_iid(cmd_iid),
		.rsp_type(cmd_type | `RSP_FLAG),
		.rsp_chan(cmd_chan),
		.rsp_code(rsp_code),
		.rsp_reason(rsp_reason),
		.tx_data(tx_data),
		.tx_valid(tx_valid),
		.tx_last(tx_last),
		.busy(tx_busy)
	);

	// ***************
	// command sequencer
	// ***************
	// the response is built while the selection is still on, so deselect only
	// drops the buffers once its own answer has left the device
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= st_idle;
			tx_start <= 1'b0;
			rsp_code <= `RESP_OK;
			rsp_reason <= `REASON_NONE;
			t1_cnt <= 3'd0;
		end else begin
			tx_start <= 1'b0;
			case (state)
				st_idle: begin
					if (cmd_valid && for_us)
						state <= st_exec;
				end
				st_exec: begin
					rsp_code <= (init_state && !is_clear) ? `RESP_FAIL : `RESP_OK;
					rsp_reason <= (init_state && !is_clear) ? `REASON_INIT_REQ :
						`REASON_NONE;
					tx_start <= 1'b1;
					state <= st_tx;
				end
				st_tx: begin
					if (!tx_start && !tx_busy) begin
						t1_cnt <= T1_COUNT;
						state <= (is_deselect && !init_state) ? st_desel_wait : st_idle;
					end
				end
				st_desel_wait: begin
					if (t1_cnt == 3'd1)
						state <= st_idle;
					t1_cnt <= t1_cnt - 3'd1;
				end
				default: state <= st_idle;
			endcase
		end
	end

	// ***************
	// initial state and instance tracking
	// ***************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			init_state <= 1'b1;
			last_iid <= 8'h00;
			last_iid_ok <= 1'b0;
			force_init_q <= 1'b0;
			last_cmd <= 8'h00;
		end else begin
			force_init_q <= force_init;
			if (init_rise) begin
				init_state <= 1'b1;
				last_iid_ok <= 1'b0;
			end else if (state == st_exec) begin
				last_cmd <= cmd_type;
				if (is_clear) begin
					init_state <= 1'b0;
					last_iid_ok <= 1'b0;
				end else if (!init_state) begin
					last_iid <= cmd_iid;
					last_iid_ok <= 1'b1;
				end
			end
		end
	end

	// ***************
	// selection and arbitration
	// ***************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pkg_selected <= 1'b0;
			arb_bypass <= 1'b0;
		end else if (init_rise) begin
			pkg_selected <= 1'b0;
		end else if (state == st_desel_wait && t1_cnt == 3'd1) begin
			pkg_selected <= 1'b0;
		end else if (state == st_exec && !is_deselect) begin
			pkg_selected <= 1'b1;
			if (is_select && !init_state)
				arb_bypass <= arb_capable ? cmd_arb_dis : 1'b1;
		end
	end

	// drive only while a response is on the wire; idle float keeps selection
	assign tx_oe = tx_valid && pkg_selected && (arb_bypass || arb_grant);

	// ***************
	// axi4-lite slave
	// ***************
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	wire [7:0] wr_addr = s_axi_awvalid && s_axi_awready ? s_axi_awaddr : awaddr_q;
	wire [31:0] wr_data = s_axi_wvalid && s_axi_wready ? s_axi_wdata : wdata_q;
	wire wr_fire = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) && !s_axi_bvalid;
	// bit 3 shows whether retry tracking holds an instance number
	wire [31:0] status_word = {16'h0000, last_cmd, 4'h0, last_iid_ok, arb_bypass, init_state,
		pkg_selected};
	wire rd_hit = s_axi_araddr == `REG_CTRL || s_axi_araddr == `REG_STATUS ||
		s_axi_araddr == `REG_LASTCMD;
	wire [31:0] rd_word = s_axi_araddr == `REG_CTRL ? ctrl :
		s_axi_araddr == `REG_STATUS ? status_word :
		s_axi_araddr == `REG_LASTCMD ? {24'h000000, last_iid} : 32'h0000_0000;

	// write channel: address and data in either order, response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			ctrl <= `CTRL_RESET;
		end else begin
			if (s_axi_awvalid && s_axi_awready)
				awaddr_q <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready)
				wdata_q <= s_axi_wdata;
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_addr == `REG_CTRL ? 2'b00 : 2'b10;
				if (wr_addr == `REG_CTRL && s_axi_wstrb[0])
					ctrl[7:0] <= wr_data[7:0];
			end else begin
				if (s_axi_awvalid && s_axi_awready)
					aw_held <= 1'b1;
				if (s_axi_wvalid && s_axi_wready)
					w_held <= 1'b1;
				if (s_axi_bvalid && s_axi_bready)
					s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read channel: one cycle to answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // sbcmd_top

/* testbench/sbcmd_top_asserts.sv */
/*
 * checker for the sideband command top: frame shape, buffer gating, axi answers.
 * assumes it is bound to sbcmd_top and sees only that module's ports.
 */
`timescale 1ns/10ps

module sbcmd_top_chk (
	// clock and reset
	input logic aclk,
	input logic aresetn,
	// response stream and buffers
	input sbcmd_pkg::byte_t tx_data,
	input logic tx_valid,
	input logic tx_last,
	input logic tx_oe,
	input logic arb_grant,
	input logic arb_bypass,
	input logic pkg_selected,
	// axi answers
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic s_axi_rvalid,
	input logic s_axi_rready
);
	import sbcmd_pkg::*;
	logic [6:0] pos;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// byte position inside the outgoing frame
	always_ff @(posedge aclk) begin
		if (!aresetn || (tx_valid && tx_last))
			pos <= 7'h00;
		else if (tx_valid)
			pos <= pos + 7'h01;
	end

	oe_sel_a: assert property (tx_oe |-> pkg_selected)
		else $error("buffers enabled while deselected");
	grant_gate_a: assert property (tx_oe && !arb_bypass |-> arb_grant)
		else $error("buffers enabled without grant");
	frame_size_a: assert property (tx_valid && tx_last |-> pos == 7'h3f)
		else $error("response frame not 64 bytes");
	dest_first_a: assert property ($rose(tx_valid) |-> tx_data == 8'hff)
		else $error("frame does not open with broadcast");
	rsp_type_a: assert property (tx_valid && pos == 7'h12 |-> tx_data[7])
		else $error("response type flag missing");
	ether_low_a: assert property (tx_valid && pos == 7'h0d |-> tx_data == 8'hf8)
		else $error("ethertype low byte wrong");
	no_gap_a: assert property (tx_valid && !tx_last |=> tx_valid)
		else $error("gap inside response frame");
	rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer held after handshake");
	wr_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer held after handshake");
endmodule // sbcmd_top_chk

bind sbcmd_top sbcmd_top_chk u_chk (.aclk(aclk), .aresetn(aresetn), .tx_data(tx_data),
	.tx_valid(tx_valid), .tx_last(tx_last), .tx_oe(tx_oe), .arb_grant(arb_grant),
	.arb_bypass(arb_bypass), .pkg_selected(pkg_selected), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

/* testbench/mgmt_model.sv */
/*
 * management controller model: sends one command frame per request and
 * collects each response frame off the shared bus.
 * assumes the bench raises go for one cycle and waits for the answer.
 */
`timescale 1ns/10ps

module mgmt_model (
	// clock and reset
	input logic aclk,
	input logic aresetn,
	// request from the bench
	input logic go,
	input logic slow,
	input logic [7:0] ctype,
	input logic [7:0] chan,
	input logic [7:0] instance_number,
	input logic [7:0] arb,
	// command stream
	output sbcmd_pkg::byte_t rx_data,
	output logic rx_valid,
	output logic rx_last,
	// response from the bus
	input sbcmd_pkg::byte_t tx_data,
	input logic tx_valid,
	input logic tx_last,
	input logic tx_oe,
	output logic done,
	output logic [39:0] rsp
);
	import sbcmd_pkg::*;
	logic [5:0] n;
	byte_t b;
	byte_t bus;

	// frame byte i; reserved and pad bytes are random on purpose
	function automatic byte_t fb(input int i);
		case (i)
			12: return 8'h88;
			13: return 8'hf8;
			14: return 8'h01;
			15: return 8'h01;
			17: return instance_number;
			18: return ctype;
			19: return chan;
			33: return arb;
			default: return (i < 6) ? 8'hff : byte_t'($urandom);
		endcase
	endfunction

	// sender: an idle cycle after every byte when slow, data line toggles when idle
	initial begin
		rx_valid = 1'b0;
		rx_last = 1'b0;
		rx_data = 8'h5a;
		forever begin
			@(posedge aclk);
			if (go) begin
				for (int i = 0; i < 64; i++) begin
					rx_data <= fb(i);
					rx_valid <= 1'b1;
					rx_last <= (i == 63);
					@(posedge aclk);
					if (slow) begin
						rx_valid <= 1'b0;
						rx_last <= 1'b0;
						rx_data <= ~rx_data;
						@(posedge aclk);
					end
				end
				rx_valid <= 1'b0;
				rx_last <= 1'b0;
				rx_data <= ~rx_data;
			end
		end
	end

	// receiver: a floating bus reads as the inverse of its last level
	assign bus = tx_oe ? tx_data : ~b;
	always @(posedge aclk) begin
		done <= 1'b0;
		if (!aresetn)
			n <= 6'h00;
		else if (tx_valid) begin
			b <= bus;
			n <= n + 6'h01;
			if (n == 6'h12)
				rsp[39:32] <= bus;
			if (n >= 6'h1e && n <= 6'h21)
				rsp[8 * (6'h21 - n) +: 8] <= bus;
			if (tx_last) begin
				n <= 6'h00;
				done <= 1'b1;
			end
		end
	end
endmodule // mgmt_model

/* testbench/sideband_cmd_pkg_select_test.sv */
/*
 * testbench of the sideband command top: initial state, selection, arbitration, registers.
 * assumes sbcmd_top, the management controller model and the bound checker.
 */
`timescale 1ns/10ps

module sideband_cmd_pkg_select_test;
	import sbcmd_pkg::*;
	typedef struct {logic [39:0] v; logic [39:0] m;} exp_t;
	localparam logic [39:0] FM = 40'hff_ffff_ffff;
	logic aclk = 1'b0, aresetn = 1'b0, go = 1'b0, slow = 1'b0, grant = 1'b1;
	logic [7:0] ctype = 8'h00, chan = 8'h00, instance_number = 8'h00, arb = 8'h00;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
	logic awready, wready, bvalid, arready, rvalid, done;
	logic rx_valid, rx_last, tx_valid, tx_last, tx_oe, bypass, sel;
	logic [1:0] bresp, rresp;
	logic [39:0] rsp;
	byte_t rx_data, tx_data;
	exp_t fq[$], aq[$], e;
	int bad_count = 0, n_tests = 0;

	always #50 aclk = ~aclk;

	sbcmd_top DUT (.aclk(aclk), .aresetn(aresetn), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_last(rx_last), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
		.tx_oe(tx_oe), .arb_grant(grant), .arb_bypass(bypass), .pkg_selected(sel),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

	mgmt_model peer (.aclk(aclk), .aresetn(aresetn), .go(go), .slow(slow), .ctype(ctype),
		.chan(chan), .instance_number(instance_number), .arb(arb), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_last(rx_last), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
		.tx_oe(tx_oe), .done(done), .rsp(rsp));

	task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		bad_count += fq.size() + aq.size(); // unanswered notes count as misses
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// one command frame; the wait covers the answer and the deselect-to-float interval
	task automatic cmd(input logic [7:0] t, c, a, input logic [39:0] v, m);
		fq.push_back('{v, m});
		ctype <= t;
		chan <= c;
		arb <= a;
		instance_number <= 8'($urandom);
		slow <= 1'($urandom);
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		for (int k = 0; k < 400 && fq.size() != 0; k++)
			@(posedge aclk);
		repeat (4) @(posedge aclk);
	endtask

	// axi write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		aq.push_back('{{6'h0, r, 32'h0}, 40'h3_0000_0000});
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
	endtask

	task automatic rd(input logic [7:0] a, input logic [33:0] v, m);
		aq.push_back('{{6'h0, v}, {6'h0, m}});
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
	endtask

	// answer watcher: the oldest note against each response frame or axi answer
	always @(posedge aclk) begin
		if (done === 1'b1 && fq.size() > 0) begin
			e = fq.pop_front();
			chk("response", rsp & e.m, e.v & e.m);
		end
		if (bvalid && aq.size() > 0) begin
			e = aq.pop_front();
			chk("bresp", {6'h0, bresp, 32'h0} & e.m, e.v & e.m);
		end
		if (rvalid && aq.size() > 0) begin
			e = aq.pop_front();
			chk("read", {6'h0, rresp, rdata} & e.m, e.v & e.m);
		end
	end

	// main sequence
	initial begin
		void'($urandom(81));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("idle after reset", {38'h0, sel, tx_oe}, 40'h0);
		cmd(8'h01, 8'h1f, 8'h00, 40'h81_0001_0001, FM);
		rd(8'h04, 34'h2, 34'h3_0000_0002);
		cmd(8'h00, 8'h1f, 8'h00, 40'h80_0000_0000, FM);
		rd(8'h04, 34'h0, 34'h3_0000_ff0a);
		$display("test initial state done");
		cmd(8'h01, 8'h1f, 8'h01, 40'h81_0000_0000, FM);
		chk("bypass set", {38'h0, sel, bypass}, 40'h3);
		rd(8'h04, 34'h10d, 34'h3_0000_ff0f);
		cmd(8'h01, 8'h1f, 8'hfe, 40'h81_0000_0000, FM);
		chk("bypass cleared", {38'h0, sel, bypass}, 40'h2);
		cmd(8'h02, 8'h1f, 8'h00, 40'h82_0000_0000, FM);
		chk("deselected", {39'h0, sel}, 40'h0);
		cmd(8'h03, 8'h00, 8'h00, 40'h83_0000_0000, 40'hff_0000_0000);
		chk("selected by channel", {39'h0, sel}, 40'h1);
		// no grant and no bypass: the bus floats, the model reads alternating inverse levels
		grant <= 1'b0;
		cmd(8'h03, 8'h00, 8'h00, 40'hff_ff00_ff00, FM);
		grant <= 1'b1;
		cmd(8'h02, 8'h1f, 8'h00, 40'h82_0000_0000, FM);
		$display("test selection done");
		wr(8'h00, 32'h0, 2'b00);
		cmd(8'h01, 8'h1f, 8'h00, 40'h81_0000_0000, FM);
		chk("bypass forced", {39'h0, bypass}, 40'h1);
		wr(8'h04, 32'hffff_ffff, 2'b10);
		rd(8'hfc, 34'h2_0000_0000, 34'h3_ffff_ffff);
		wr(8'h00, 32'h10, 2'b00);
		rd(8'h00, 34'h10, 34'h3_ffff_ffff);
		chk("forced deselect", {39'h0, sel}, 40'h0);
		cmd(8'h01, 8'h1f, 8'h01, 40'h81_0001_0001, FM);
		$display("test registers done");
		wrap_up();
	end

	// watchdog: the sequence needs well under 6000 cycles
	initial begin
		#(20000 * 100);
		bad_count++;
		wrap_up();
	end
endmodule // sideband_cmd_pkg_select_test
